// File: bench/pin_model.sv
// Pad partner: resolves each pad from the port drive and the outside drive
`timescale 1ns/1ns
module pin_model (
  // Clock and pads
  input  wire logic       clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_oe,
  output logic      [7:0] pin_in
);
  logic [7:0] float_v = 8'h00;
  // Undriven pads wander, never hold a stale level
  always @(posedge clk) float_v <= ~float_v;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val)
                | (~pin_oe & ~ext_oe & float_v);
endmodule

// File: bench/port_c_gpio_chk.sv
// Checker: port timing and pin relations
`timescale 1ns/1ns
module port_c_gpio_chk #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic                       ref_clk,
  input wire logic                       rst_b,
  input wire port_c_pkg::reg_req_type    reg_req,
  input wire logic [7:0]                 reg_rdata,
  input wire logic [WIDTH-1:0]           pin_in,
  input wire logic [WIDTH-1:0]           pin_out,
  input wire logic [WIDTH-1:0]           pin_oe,
  input wire port_c_pkg::periph_out_type periph_out,
  input wire logic [WIDTH-1:0]           digital_in,
  input wire logic [WIDTH-1:0]           analog_sel,
  input wire logic                       comp_b_noninv_sel,
  input wire logic [2:0]                 comp_inv_sel,
  input wire logic                       slave_select_b,
  input wire logic                       ccp_in
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  AST_OE_DIR: assert property (reg_req.wr && reg_req.addr == 2'h1 |-> ##2
    pin_oe == (~$past(reg_req.wdata, 2) & 8'hF7)) else $error("drive enable mismatch");
  AST_OE_B3: assert property (pin_oe[3] == 1'b0) else $error("pin 3 driven");
  AST_RD_IDLE: assert property (!$past(reg_req.rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  AST_RD_ANA: assert property (reg_req.rd && reg_req.addr == 2'h0
    |=> (reg_rdata & analog_sel) == 8'h00) else $error("analog pin read not zero");
  AST_DIN_ANA: assert property ($stable(analog_sel) |-> (digital_in & analog_sel) == 8'h00)
    else $error("analog pin seen as digital");
  AST_ANA_45: assert property (analog_sel[5:4] == 2'b00) else $error("pins 4 5 analog");
  AST_CMP_SEL: assert property ({comp_inv_sel, comp_b_noninv_sel} == analog_sel[3:0])
    else $error("comparator select mismatch");
  AST_SS_ANA: assert property (analog_sel[6] && $stable(analog_sel) |-> slave_select_b)
    else $error("slave select active on analog pin");
  AST_SER_PIN: assert property ((periph_out.serial_out_en
    && $stable(periph_out)) [*3] |-> pin_out[7] == periph_out.serial_out)
    else $error("serial out not on pin 7");
  AST_LATCH: assert property (reg_req.wr && reg_req.addr == 2'h0 ##1 periph_out == '0
    |=> (pin_out & pin_oe) == ($past(reg_req.wdata, 2) & pin_oe)) else $error("latch drive");
endmodule
bind port_c_gpio port_c_gpio_chk #(.WIDTH(WIDTH)) i_port_c_gpio_chk (.ref_clk(ref_clk),
  .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe(pin_oe), .periph_out(periph_out), .digital_in(digital_in), .analog_sel(analog_sel),
  .comp_b_noninv_sel(comp_b_noninv_sel), .comp_inv_sel(comp_inv_sel),
  .slave_select_b(slave_select_b), .ccp_in(ccp_in));

// File: bench/port_c_gpio_tb_top.sv
// Bench: register and pad checks of the port block
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module port_c_gpio_tb_top;
  logic                       ref_clk = 1'b0;
  logic                       rst_b   = 1'b0;
  port_c_pkg::reg_req_type    req     = '0;
  port_c_pkg::periph_out_type per     = '0;
  logic [7:0]                 rdata, pin_in, pin_out, pin_oe, din, asel, got;
  logic [7:0]                 ext_val = 8'h00;
  logic [7:0]                 ext_oe  = 8'hFF;
  logic [2:0]                 inv;
  logic                       noninv, ss_b, ccp;
  int                         n_mismatch = 0;
  int                         tests_run  = 0;
  // Rows: direction, latch, pad level, drive enable, data read
  logic [39:0] rows [4] = '{40'h00A500F7A5, 40'hFFA53C003C, 40'h0F5AC3F053, 40'hF00F08070F};
  always #25 ref_clk = ~ref_clk;
  port_c_gpio i_port_c_gpio (.ref_clk(ref_clk), .rst_b(rst_b), .reg_req(req), .reg_rdata(rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .periph_out(per), .digital_in(din),
    .analog_sel(asel), .comp_b_noninv_sel(noninv), .comp_inv_sel(inv), .slave_select_b(ss_b),
    .ccp_in(ccp));
  pin_model i_pin_model (.clk(ref_clk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
    .ext_oe(ext_oe), .pin_in(pin_in));
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Covers synchroniser plus output register
  task automatic settle();
    repeat (6) @(posedge ref_clk);
    #1;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_mismatch++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    wr(port_c_pkg::ADDR_ANALOG_LOW, 8'h00);
    wr(port_c_pkg::ADDR_ANALOG_HIGH, 8'h00);
    foreach (rows[i]) begin
      wr(port_c_pkg::ADDR_DIRECTION, rows[i][39:32]);
      wr(port_c_pkg::ADDR_PIN_DATA, rows[i][31:24]);
      ext_val <= rows[i][23:16];
      settle();
      `CHK("oe", rows[i][15:8], pin_oe)
      `CHK("out", rows[i][31:24] & rows[i][15:8], pin_out & rows[i][15:8])
      rd(port_c_pkg::ADDR_PIN_DATA, got);
      `CHK("read", rows[i][7:0], got)
    end
    // Mid-run reset, pads pulled high from outside
    @(posedge ref_clk);
    rst_b <= 1'b0;
    ext_val <= 8'hFF;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    settle();
    `CHK("oe rst", 8'h00, pin_oe)
    `CHK("ss rst", 1'b1, ss_b)
    `CHK("asel rst", 8'hCF, asel)
    rd(port_c_pkg::ADDR_DIRECTION, got);
    `CHK("dir rst", 8'hFF, got)
    rd(port_c_pkg::ADDR_PIN_DATA, got);
    `CHK("rd rst", 8'h30, got)
    rd(port_c_pkg::ADDR_ANALOG_LOW, got);
    `CHK("alo rst", 8'hFF, got)
    wr(port_c_pkg::ADDR_ANALOG_HIGH, 8'hF2);
    rd(port_c_pkg::ADDR_ANALOG_HIGH, got);
    `CHK("ahi mask", 8'h02, got)
    wr(port_c_pkg::ADDR_DIRECTION, 8'h00);
    rd(port_c_pkg::ADDR_DIRECTION, got);
    `CHK("dir ro", 8'h08, got)
    settle();
    `CHK("oe ana", 8'hF7, pin_oe)
    wr(port_c_pkg::ADDR_ANALOG_LOW, 8'h00);
    wr(port_c_pkg::ADDR_ANALOG_HIGH, 8'h00);
    wr(port_c_pkg::ADDR_DIRECTION, 8'h6F);
    ext_val <= 8'h00;
    // Pwm output b stays off beside the comparator output
    per <= '{serial_out_en: 1'b1, serial_out: 1'b1, comp_b_out_en: 1'b1, comp_b_out: 1'b1,
             default: 1'b0};
    settle();
    `CHK("pins", 8'h90, pin_out & 8'h90)
    `CHK("din", 8'h90, din)
    `CHK("ss", 1'b0, ss_b)
    `CHK("ccp", 1'b0, ccp)
    wr(port_c_pkg::ADDR_ANALOG_LOW, 8'hF0);
    ext_val <= 8'hFF;
    settle();
    `CHK("din ana", 8'hF0, din)
    `CHK("sel", 4'hF, {inv, noninv})
    `CHK("ccp hi", 1'b1, ccp)
    rd(port_c_pkg::ADDR_PIN_DATA, got);
    `CHK("rd ana", 8'hF0, got)
    // Comparator output handed back in the same step as pwm output b takes pin 4
    wr(port_c_pkg::ADDR_DIRECTION, 8'h00);
    per <= '{serial_out_en: 1'b1, serial_out: 1'b1, pwm_a_en: 1'b1, pwm_b_en: 1'b1, pwm_b: 1'b1,
             pwm_c_en: 1'b1, pwm_c: 1'b1, pwm_d_en: 1'b1, pwm_d: 1'b1, ccp_out_en: 1'b1,
             ccp_out: 1'b1, default: 1'b0};
    settle();
    `CHK("pwm", 8'h9C, pin_out & 8'hBC)
    @(posedge ref_clk);
    per.pwm_a_en <= 1'b0;
    settle();
    `CHK("ccp out", 1'b1, pin_out[5])
    `CHK("ccp loop", 1'b1, ccp)
    conclude();
  end
endmodule

// File: rtl/pin_sync.sv
// Two-stage synchroniser for the pin inputs
`timescale 1ns/1ns
module pin_sync #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  // First stage feeds only the second
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_one <= '0;
      sync_out  <= '0;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule

// File: rtl/port_c_gpio.sv
// Eight-bit bidirectional port with analog select and peripheral pin sharing
// Functional notes
// - A pin whose direction bit is one is an input with its driver off.
// - A pin whose direction bit is zero drives its output latch value.
// - Reading the data register returns the sampled pin levels, not the latch.
// - A write is read-modify-write: pin levels are read, modified and stored in the latch. Here the written byte goes straight into the latch, no pins read.
// - The direction bits gate the drivers even on pins used as analog inputs.
// - A pin configured as analog input reads as zero through the data register.
// - Eight data and eight direction bits, pin bit n at register bit n.
// - Direction bits reset to one, and one means input.
// - Pin 0 is digital I/O, converter input or comparator B non-inverting input.
// - Pins 1 to 3 are digital, converter or comparator inverting inputs; 2 and 3 carry PWM. Here direction bit 3 stays one, so pin 3 never drives its PWM.
// - Pin 4 is digital I/O, comparator B output or a PWM output.
// - Pin 5 is digital I/O, the capture/compare pin or the primary PWM output.
// - Pin 6 is digital I/O, converter input or the serial slave-select input.
// - Pin 7 is digital I/O, converter input or the serial data output.
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
module port_c_gpio #(
  parameter int unsigned WIDTH = port_c_pkg::WIDTH
) (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst_b,
  // Register port
  input  wire port_c_pkg::reg_req_type    reg_req,
  output logic [7:0]                      reg_rdata,
  // Pins
  input  wire logic [WIDTH-1:0]           pin_in,
  output logic [WIDTH-1:0]                pin_out,
  output logic [WIDTH-1:0]                pin_oe,
  // Peripheral side
  input  wire port_c_pkg::periph_out_type periph_out,
  output logic [WIDTH-1:0]                digital_in,
  output logic [WIDTH-1:0]                analog_sel,
  output logic                            comp_b_noninv_sel,
  output logic [2:0]                      comp_inv_sel,
  output logic                            slave_select_b,
  output logic                            ccp_in
);

  logic [WIDTH-1:0] port_pin_bits;
  logic [WIDTH-1:0] output_latch;
  logic [WIDTH-1:0] direction_bits;
  logic [7:0]       analog_select_low;
  logic [7:0]       analog_select_high;
  logic [WIDTH-1:0] analog_map;
  logic [WIDTH-1:0] pin_read;
  logic [WIDTH-1:0] next_pin_out;
  logic [WIDTH-1:0] next_rmw;

  // One decode shared by every register write
  function automatic logic write_hit(input port_c_pkg::reg_req_type req,
                                     input logic [1:0]              addr);
    return req.wr && (req.addr == addr);
  endfunction

  // Pins cross into the clock domain
  pin_sync #(
    .WIDTH(WIDTH)
  ) u_pin_sync (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .async_in (pin_in),
    .sync_out (port_pin_bits)
  );

  // Analog channel of each pin; pins 4 and 5 have none
  always_comb begin
    analog_map    = '0;
    analog_map[0] = analog_select_low[port_c_pkg::ANS_PIN0];
    analog_map[1] = analog_select_low[port_c_pkg::ANS_PIN1];
    analog_map[2] = analog_select_low[port_c_pkg::ANS_PIN2];
    analog_map[3] = analog_select_low[port_c_pkg::ANS_PIN3];
    analog_map[6] = analog_select_high[port_c_pkg::ANS_PIN6];
    analog_map[7] = analog_select_high[port_c_pkg::ANS_PIN7];
  end

  // Analog pins read zero
  assign pin_read = port_pin_bits & ~analog_map;

  // Whole-byte write stores into the latch; the read half of read-modify-write
  // is the caller's, so a full write leaves nothing of the read to merge
  assign next_rmw = reg_req.wdata[WIDTH-1:0];

  // Output latch
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      output_latch <= port_c_pkg::RESET_LATCH;
    end else if (write_hit(reg_req, port_c_pkg::ADDR_PIN_DATA)) begin
      output_latch <= next_rmw;
    end
  end

  // Direction register, bit 3 read-only
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      direction_bits <= port_c_pkg::RESET_DIRECTION;
    end else if (write_hit(reg_req, port_c_pkg::ADDR_DIRECTION)) begin
      direction_bits <= (reg_req.wdata & port_c_pkg::MASK_DIRECTION_WR)
                      | (direction_bits & ~port_c_pkg::MASK_DIRECTION_WR);
    end
  end

  // Analog select registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      analog_select_low  <= port_c_pkg::RESET_ANALOG_LOW;
      analog_select_high <= port_c_pkg::RESET_ANALOG_HIGH;
    end else begin
      if (write_hit(reg_req, port_c_pkg::ADDR_ANALOG_LOW)) begin
        analog_select_low <= reg_req.wdata;
      end
      // Upper nibble has no channels behind it and reads zero
      if (write_hit(reg_req, port_c_pkg::ADDR_ANALOG_HIGH)) begin
        analog_select_high <= reg_req.wdata & port_c_pkg::MASK_ANALOG_HIGH;
      end
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        port_c_pkg::ADDR_PIN_DATA:   reg_rdata <= pin_read;
        port_c_pkg::ADDR_DIRECTION:  reg_rdata <= direction_bits;
        port_c_pkg::ADDR_ANALOG_LOW:  reg_rdata <= analog_select_low;
        port_c_pkg::ADDR_ANALOG_HIGH: reg_rdata <= analog_select_high;
        default:                     reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Peripheral outputs replace latch values on their pins
  always_comb begin
    next_pin_out = output_latch;
    if (periph_out.pwm_d_en) begin
      next_pin_out[2] = periph_out.pwm_d;
    end
    if (periph_out.pwm_c_en) begin
      next_pin_out[3] = periph_out.pwm_c;
    end
    // Both owners of pin 4 at once is a software fault; comparator wins here
    if (periph_out.comp_b_out_en) begin
      next_pin_out[port_c_pkg::PIN_COMP_OUT] = periph_out.comp_b_out;
    end else if (periph_out.pwm_b_en) begin
      next_pin_out[port_c_pkg::PIN_COMP_OUT] = periph_out.pwm_b;
    end
    if (periph_out.pwm_a_en) begin
      next_pin_out[port_c_pkg::PIN_CCP] = periph_out.pwm_a;
    end else if (periph_out.ccp_out_en) begin
      next_pin_out[port_c_pkg::PIN_CCP] = periph_out.ccp_out;
    end
    if (periph_out.serial_out_en) begin
      next_pin_out[port_c_pkg::PIN_SERIAL_OUT] = periph_out.serial_out;
    end
  end

  // Pin drivers, registered; direction alone gates the enable, analog or not
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_out <= '0;
      pin_oe  <= '0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe  <= ~direction_bits;
    end
  end

  // Peripheral-side views of the pins
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      digital_in        <= '0;
      analog_sel        <= '0;
      comp_b_noninv_sel <= 1'b0;
      comp_inv_sel      <= 3'h0;
      slave_select_b    <= 1'b1;
      ccp_in            <= 1'b0;
    end else begin
      digital_in        <= pin_read;
      analog_sel        <= analog_map;
      comp_b_noninv_sel <= analog_map[0];
      comp_inv_sel      <= analog_map[3:1];
      slave_select_b    <= analog_map[port_c_pkg::PIN_SLAVE]
                           | port_pin_bits[port_c_pkg::PIN_SLAVE];
      ccp_in            <= port_pin_bits[port_c_pkg::PIN_CCP];
    end
  end

endmodule

// File: rtl/port_c_pkg.sv
// Package: register map, reset values and carrier types of the port block
package port_c_pkg;

  localparam int unsigned WIDTH = 8;

  // Register indices on the plain register port
  localparam logic [1:0] ADDR_PIN_DATA   = 2'h0;
  localparam logic [1:0] ADDR_DIRECTION  = 2'h1;
  localparam logic [1:0] ADDR_ANALOG_LOW  = 2'h2;
  localparam logic [1:0] ADDR_ANALOG_HIGH = 2'h3;

  // Reset values
  localparam logic [7:0] RESET_LATCH      = 8'h00;
  localparam logic [7:0] RESET_DIRECTION  = 8'hFF;
  localparam logic [7:0] RESET_ANALOG_LOW  = 8'hFF;
  localparam logic [7:0] RESET_ANALOG_HIGH = 8'h0F;
  localparam logic [7:0] MASK_ANALOG_HIGH  = 8'h0F;
  // Direction bit 3 is read-only
  localparam logic [7:0] MASK_DIRECTION_WR = 8'hF7;

  // Analog channel positions of pins 0..3 in the low select, 6..7 in the high select
  localparam int unsigned ANS_PIN0 = 4;
  localparam int unsigned ANS_PIN1 = 5;
  localparam int unsigned ANS_PIN2 = 6;
  localparam int unsigned ANS_PIN3 = 7;
  localparam int unsigned ANS_PIN6 = 0;
  localparam int unsigned ANS_PIN7 = 1;

  // Pin positions
  localparam int unsigned PIN_COMP_OUT = 4;
  localparam int unsigned PIN_CCP      = 5;
  localparam int unsigned PIN_SLAVE    = 6;
  localparam int unsigned PIN_SERIAL_OUT = 7;

  // Register port request
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_type;

  // Peripheral outputs that may own pins
  typedef struct packed {
    logic pwm_a_en;
    logic pwm_a;
    logic pwm_b_en;
    logic pwm_b;
    logic pwm_c_en;
    logic pwm_c;
    logic pwm_d_en;
    logic pwm_d;
    logic comp_b_out_en;
    logic comp_b_out;
    logic ccp_out_en;
    logic ccp_out;
    logic serial_out_en;
    logic serial_out;
  } periph_out_type;

endpackage
